/* fpc_flash_program_control.v */
// Purpose: flash program/erase sequencer with boot bank alias swap, AXI4-Lite slave
// Assumes: aclk 40 MHz; aresetn and por_resetn synchronous, active low
// Notes: flash array answers each command with a one-cycle flash_done pulse
//
// Contract
// - swap bit takes a write only with write enable set and unlock done
// - swap 1 maps bank 2 low, bank 1 high; swap 0 the reverse
// - operation code field writable only while write enable is set
// - code 0001 programs one word at the target address unless protected
// - code 0010 programs the 128-bit word at target address unless protected
// - code 0011 programs the addressed row unless protected
// - code 0100 erases the addressed page unless protected
// - code 0101 erases lower region only if all its pages are unprotected
// - code 0110 erases upper region only if all its pages are unprotected
// - code 0111 erases all flash only when protect boundary is zero
// - swap and operation code bits reset only by power-on reset
// - word program does nothing when ecc is enabled at all times
// - otherwise word program runs without writing that word's ecc bits
// - control bits 5 and 4 read as zero
`include "fpc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module fpc_flash_program_control (
   input wire aclk, // system clock
   input wire aresetn, // system reset, active low
   input wire por_resetn, // power-on reset, active low
   input wire [7:0] s_axi_awaddr, // write address
   input wire [2:0] s_axi_awprot, // write protection type, unused
   input wire s_axi_awvalid, // write address valid
   output wire s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // write byte enables
   input wire s_axi_wvalid, // write data valid
   output wire s_axi_wready, // write data ready
   output reg [1:0] s_axi_bresp, // write response
   output reg s_axi_bvalid, // write response valid
   input wire s_axi_bready, // write response ready
   input wire [7:0] s_axi_araddr, // read address
   input wire [2:0] s_axi_arprot, // read protection type, unused
   input wire s_axi_arvalid, // read address valid
   output wire s_axi_arready, // read address ready
   output reg [31:0] s_axi_rdata, // read data
   output reg [1:0] s_axi_rresp, // read response
   output reg s_axi_rvalid, // read data valid
   input wire s_axi_rready, // read data ready
   output reg flash_cmd_valid, // one-cycle command strobe to the array
   output reg [3:0] flash_cmd_op, // operation code of the command
   output reg [31:0] flash_cmd_addr, // target address of the command
   output reg flash_cmd_skip_ecc, // word program must not write ecc bits
   input wire flash_done, // array finished the command, one-cycle pulse
   output wire lower_alias_bank2, // lower boot alias shows bank 2
   output wire upper_alias_bank2 // upper boot alias shows bank 2
);

   ////////////////////////////////////////////////////////////////////////
   // state

   reg [3:0] op_q; // survives system reset
   reg swap_q; // survives system reset
   reg write_enable_gate_q;
   reg unlock_q;
   reg key1_seen_q;
   reg busy_q;
   reg err_q;
   reg [31:0] addr_q;
   reg [23:0] prot_q;
   reg [1:0] ecc_q;
   reg aw_held_q;
   reg w_held_q;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;

   // byte-lane merge of a write onto the old register value
   function [31:0] fpc_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] strb;
      integer i;
      begin
         fpc_merge = old_v;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               fpc_merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
         end
      end
   endfunction

   // offsets that answer OKAY
   function fpc_mapped;
      input [7:0] a;
      begin
         fpc_mapped = (a == `FPC_OFS_CTRL) || (a == `FPC_OFS_KEY) ||
                      (a == `FPC_OFS_ADDR) || (a == `FPC_OFS_PROT) ||
                      (a == `FPC_OFS_ECC);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // write channel: address and data taken in either order

   assign s_axi_awready = ~aw_held_q;
   assign s_axi_wready = ~w_held_q;

   wire wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
   // control word as read back; the start position shows busy
   wire [31:0] ctrl_rd = {16'h0000, busy_q, write_enable_gate_q, err_q, 6'b00_0000, swap_q,
                          2'b00, op_q};
   wire [31:0] ctrl_new = fpc_merge(ctrl_rd, wdata_q, wstrb_q);
   wire ctrl_wr = wr_fire & (awaddr_q == `FPC_OFS_CTRL);
   wire key_wr = wr_fire & (awaddr_q == `FPC_OFS_KEY);
   wire start_req = ctrl_wr & ctrl_new[`FPC_START_BIT] & write_enable_gate_q & ~busy_q;

   // the code written along with the start bit is the one that runs
   wire [3:0] op_new = ctrl_new[`FPC_OP_MSB:`FPC_OP_LSB];

   // hold address and data until both are present
   // a new address may be held while bvalid still waits; it lands once bvalid drops
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FPC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_held_q) begin
            aw_held_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && !w_held_q) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= fpc_mapped(awaddr_q) ? `FPC_RESP_OKAY : `FPC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power-on-only fields: swap and operation code

   // system reset leaves these alone so a warm restart keeps the bank map
   // gates are taken from before this write, so write_enable_gate must be set by an earlier write
   always @(posedge aclk) begin
      if (!por_resetn) begin
         op_q <= `FPC_OP_RST;
         swap_q <= `FPC_SWAP_RST;
      end else if (ctrl_wr) begin
         if (write_enable_gate_q) begin
            op_q <= ctrl_new[`FPC_OP_MSB:`FPC_OP_LSB];
         end
         if (write_enable_gate_q && unlock_q) begin
            swap_q <= ctrl_new[`FPC_SWAP_BIT];
         end
      end
   end

   // bank 1 is the default; the swap bit exchanges the two aliases
   assign lower_alias_bank2 = swap_q;
   assign upper_alias_bank2 = ~swap_q;

   ////////////////////////////////////////////////////////////////////////
   // write enable, unlock sequence and plain registers

   // boundary is 24 bits wide; the top byte lane of a write is dropped here
   wire [31:0] prot_new = fpc_merge({8'h00, prot_q}, wdata_q, wstrb_q);

   // unlock lasts until the next control or key register write, so each gated write needs a fresh key pair
   always @(posedge aclk) begin
      if (!aresetn) begin
         write_enable_gate_q <= 1'b0;
         unlock_q <= 1'b0;
         key1_seen_q <= 1'b0;
         addr_q <= 32'h0000_0000;
         prot_q <= `FPC_PROT_RST;
         ecc_q <= `FPC_ECC_RST;
      end else begin
         if (ctrl_wr) begin
            write_enable_gate_q <= ctrl_new[`FPC_WRITE_ENABLE_GATE_BIT];
            unlock_q <= 1'b0;
            key1_seen_q <= 1'b0;
         end
         if (key_wr) begin
            key1_seen_q <= (wdata_q == `FPC_KEY1);
            unlock_q <= key1_seen_q && (wdata_q == `FPC_KEY2);
         end
         if (wr_fire && awaddr_q == `FPC_OFS_ADDR) begin
            addr_q <= fpc_merge(addr_q, wdata_q, wstrb_q);
         end
         if (wr_fire && awaddr_q == `FPC_OFS_PROT) begin
            prot_q <= prot_new[23:0];
         end
         if (wr_fire && awaddr_q == `FPC_OFS_ECC && wstrb_q[0]) begin
            ecc_q <= wdata_q[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // operation check: protection, region and ecc gating

   // pages below the protect boundary are write-protected
   // lower region lies below the upper base, so any nonzero boundary protects part of it
   // upper region is clear of protection once the boundary sits at or below its base
   wire addr_prot = (addr_q[23:0] < prot_q) || (addr_q[31:24] != 8'h00);
   reg op_ok;
   always @* begin
      case (op_new)
         `FPC_OP_NOP: op_ok = 1'b0;
         `FPC_OP_WORD: op_ok = ~addr_prot & (ecc_q != `FPC_ECC_ALWAYS);
         `FPC_OP_QUAD: op_ok = ~addr_prot;
         `FPC_OP_ROW: op_ok = ~addr_prot;
         `FPC_OP_PAGE: op_ok = ~addr_prot;
         `FPC_OP_LOWER: op_ok = (prot_q == 24'h00_0000);
         `FPC_OP_UPPER: op_ok = (prot_q <= `FPC_UPPER_BASE);
         `FPC_OP_ALL: op_ok = (prot_q == 24'h00_0000);
         default: op_ok = 1'b0; // reserved codes do nothing
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // command issue and busy tracking

   // a refused start other than a no-op raises the error flag instead of touching the array
   // a start while busy is dropped; software polls the busy bit before the next one
   // err is cleared only by system reset, the next accepted command or a refused no-op
   always @(posedge aclk) begin
      if (!aresetn) begin
         busy_q <= 1'b0;
         err_q <= 1'b0;
         flash_cmd_valid <= 1'b0;
         flash_cmd_op <= `FPC_OP_NOP;
         flash_cmd_addr <= 32'h0000_0000;
         flash_cmd_skip_ecc <= 1'b0;
      end else begin
         flash_cmd_valid <= 1'b0;
         if (busy_q && flash_done) begin
            busy_q <= 1'b0;
         end
         if (start_req) begin
            if (op_ok) begin
               busy_q <= 1'b1;
               err_q <= 1'b0;
               flash_cmd_valid <= 1'b1;
               flash_cmd_op <= op_new;
               flash_cmd_addr <= addr_q;
               flash_cmd_skip_ecc <= (op_new == `FPC_OP_WORD);
            end else begin
               err_q <= (op_new != `FPC_OP_NOP);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read channel: one-cycle answer

   assign s_axi_arready = ~s_axi_rvalid;

   reg [31:0] rd_mux;
   always @* begin
      case ({s_axi_araddr[7:2], 2'b00})
         `FPC_OFS_CTRL: rd_mux = ctrl_rd;
         `FPC_OFS_ADDR: rd_mux = addr_q;
         `FPC_OFS_PROT: rd_mux = {8'h00, prot_q};
         `FPC_OFS_ECC: rd_mux = {30'h0000_0000, ecc_q};
         default: rd_mux = 32'h0000_0000; // key register reads zero
      endcase
   end

   // capture data when the address is taken
   // the address is decoded straight from the bus, so no read address register is kept
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `FPC_RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= fpc_mapped({s_axi_araddr[7:2], 2'b00}) ? `FPC_RESP_OKAY :
                        `FPC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

/* fpc_consts.vh */
// Purpose: constants for the flash program control block
// Assumes: 32-bit AXI4-Lite register access, 40 MHz aclk
// Notes: definitions only
`ifndef FPC_CONSTS_VH
`define FPC_CONSTS_VH

// register byte offsets
`define FPC_OFS_CTRL 8'h00
`define FPC_OFS_KEY 8'h04
`define FPC_OFS_ADDR 8'h08
`define FPC_OFS_PROT 8'h0C
`define FPC_OFS_ECC 8'h10

// control register fields
`define FPC_OP_LSB 0
`define FPC_OP_MSB 3
`define FPC_SWAP_BIT 6
`define FPC_ERR_BIT 13
`define FPC_WRITE_ENABLE_GATE_BIT 14
`define FPC_START_BIT 15

// reset values
`define FPC_OP_RST 4'h0
`define FPC_SWAP_RST 1'b0
`define FPC_PROT_RST 24'h00_0000
`define FPC_ECC_RST 2'b11

// unlock keys, written in this order to the key register
`define FPC_KEY1 32'hAA99_6655
`define FPC_KEY2 32'h5566_99AA

// operation codes
`define FPC_OP_NOP 4'h0
`define FPC_OP_WORD 4'h1
`define FPC_OP_QUAD 4'h2
`define FPC_OP_ROW 4'h3
`define FPC_OP_PAGE 4'h4
`define FPC_OP_LOWER 4'h5
`define FPC_OP_UPPER 4'h6
`define FPC_OP_ALL 4'h7

// ecc setting meaning ecc enabled at all times
`define FPC_ECC_ALWAYS 2'b00

// first byte address of the upper mapped flash region
`define FPC_UPPER_BASE 24'h04_0000

// axi responses
`define FPC_RESP_OKAY 2'b00
`define FPC_RESP_SLVERR 2'b10

`endif

/* fpc_checker.sv */
// Purpose: port assertions for the flash program control block
// Assumes: one aclk domain, aresetn synchronous active low
// Notes: of the two resets, only por_resetn may move the alias outputs
`timescale 1ns/1ps
`default_nettype none
module fpc_checker (
   input wire logic aclk, // clock
   input wire logic aresetn, // system reset
   input wire logic por_resetn, // power-on reset
   input wire logic s_axi_bvalid, // write response valid
   input wire logic flash_cmd_valid, // command strobe
   input wire logic [3:0] flash_cmd_op, // command code
   input wire logic [31:0] flash_cmd_addr, // command target
   input wire logic flash_cmd_skip_ecc, // ecc bits left unwritten
   input wire logic lower_alias_bank2, // lower alias shows bank 2
   input wire logic upper_alias_bank2 // upper alias shows bank 2
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////
   // a command leaves with the write response and lasts one cycle
   sequence s_cmd;
      $rose(s_axi_bvalid) ##1 !flash_cmd_valid;
   endsequence
   property p_cmd; flash_cmd_valid |-> s_cmd; endproperty
   a_cmd: assert property (p_cmd) else $error("command strobe misplaced");
   property p_alias; lower_alias_bank2 != upper_alias_bank2; endproperty
   a_alias: assert property (p_alias) else $error("aliases not swapped pair");
   property p_nop; flash_cmd_valid |-> flash_cmd_op != 4'h0; endproperty
   a_nop: assert property (p_nop) else $error("no-op reached the array");
   property p_rsvd; flash_cmd_valid |-> !flash_cmd_op[3]; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved code reached the array");
   property p_ecc; flash_cmd_valid && flash_cmd_op == 4'h1 |-> flash_cmd_skip_ecc; endproperty
   a_ecc: assert property (p_ecc) else $error("word program writes ecc");
   property p_prot;
      flash_cmd_valid && flash_cmd_op inside {[1:4]} |-> flash_cmd_addr[31:24] == 8'h00;
   endproperty
   a_prot: assert property (p_prot) else $error("command to protected place");
   // the alias only moves by a bus write or by power-on reset
   property p_swap; $changed(lower_alias_bank2) && $past(por_resetn) |-> $rose(s_axi_bvalid);
   endproperty
   a_swap: assert property (p_swap) else $error("alias moved without write");
   property p_keep; disable iff (!por_resetn) !aresetn |=> $stable(lower_alias_bank2);
   endproperty
   a_keep: assert property (p_keep) else $error("system reset moved alias");
endmodule
bind fpc_flash_program_control fpc_checker u_chk (.aclk, .aresetn, .por_resetn,
   .s_axi_bvalid, .flash_cmd_valid, .flash_cmd_op, .flash_cmd_addr, .flash_cmd_skip_ecc,
   .lower_alias_bank2, .upper_alias_bank2);
`default_nettype wire

/* fpc_flash_model.sv */
// Purpose: behavioural flash array answering each command
// Assumes: one-cycle command strobe
// Notes: slow mode stands for a long erase, fast for a short program
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_model (
   input wire logic aclk, // clock
   input wire logic aresetn, // system reset, active low
   input wire logic cmd_valid, // command strobe
   input wire logic slow, // long busy time
   output logic done // one-cycle finish pulse
);
   logic [3:0] cnt_q;
   // busy countdown; done pulses once as it expires
   always @(posedge aclk) begin
      done <= 1'b0;
      if (!aresetn) begin
         cnt_q <= 4'h0;
      end else if (cmd_valid) begin
         cnt_q <= slow ? 4'h9 : 4'h1;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
         done <= (cnt_q == 4'h1);
      end
   end
endmodule
`default_nettype wire

/* tb.sv */
// Purpose: self-checking bench for the flash program control block
// Assumes: 40 MHz aclk, AXI4-Lite master, seed 91
// Notes: command outcome predicted by function go
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic aclk, aresetn, por_resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, slow;
   logic s_axi_arvalid, s_axi_rready, flash_done, errx, g;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, rd, a;
   logic [3:0] s_axi_wstrb, op;
   logic [23:0] b;
   logic [1:0] e;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata, flash_cmd_addr;
   wire flash_cmd_valid, flash_cmd_skip_ecc, lower_alias_bank2, upper_alias_bank2;
   wire [3:0] flash_cmd_op;
   integer err_count, total_checks, ncmd, n0, i, n, k;
   fpc_flash_program_control uut (.aclk, .aresetn, .por_resetn, .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_cmd_valid, .flash_cmd_op,
      .flash_cmd_addr, .flash_cmd_skip_ecc, .flash_done, .lower_alias_bank2,
      .upper_alias_bank2);
   fpc_flash_model u_flash (.aclk, .aresetn, .cmd_valid(flash_cmd_valid), .slow,
      .done(flash_done));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   // commands seen by the array
   always @(posedge aclk) if (flash_cmd_valid) ncmd <= ncmd + 1;
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", total_checks, err_count);
         if (err_count == 0 && total_checks > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // one write (w=1) or read; each valid held until its own ready
   task bus(input w, input [7:0] ad, input [31:0] d, input [1:0] re);
      begin
         n = 0;
         @(posedge aclk);
         s_axi_awaddr <= ad;
         s_axi_araddr <= ad;
         s_axi_wdata <= d;
         s_axi_awvalid <= w;
         s_axi_wvalid <= w;
         s_axi_bready <= w;
         s_axi_arvalid <= !w;
         s_axi_rready <= !w;
         do begin
            @(posedge aclk);
            n = n + 1;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 40);
         s_axi_bready <= 1'b0;
         s_axi_rready <= 1'b0;
         rd = s_axi_rdata;
         if ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1) begin
            err_count = err_count + 1;
            end_sim;
         end
         chk(32'(w ? s_axi_bresp : s_axi_rresp), 32'(re));
      end
   endtask
   // whether the array should receive a command
   function automatic logic go(input [3:0] o, input [31:0] ad, input [23:0] bd,
      input [1:0] ec);
      logic p;
      begin
         p = (ad[31:24] != 8'h00) || (ad[23:0] < bd);
         case (o)
            4'h1: go = !p && ec != 2'b00;
            4'h2, 4'h3, 4'h4: go = !p;
            4'h5, 4'h7: go = bd == 24'h00_0000;
            4'h6: go = bd <= 24'h04_0000;
            default: go = 1'b0;
         endcase
      end
   endfunction
   initial begin
      {aresetn, por_resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
      {s_axi_arvalid, s_axi_rready, slow, errx} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0_0000_0000_000F;
      {err_count, total_checks, ncmd} = 96'h0;
      void'($urandom(91));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      por_resetn <= 1'b1;
      bus(0, 8'h00, 0, 2'b00);
      chk(rd, 32'h0000_0000);
      bus(0, 8'h10, 0, 2'b00);
      chk(rd, 32'h0000_0003);
      chk(32'({lower_alias_bank2, upper_alias_bank2}), 32'h0000_0001);
      bus(1, 8'h00, 32'h0000_0077, 2'b00);
      bus(0, 8'h00, 0, 2'b00);
      chk(rd, 32'h0000_0000);
      bus(1, 8'h00, 32'h0000_4000, 2'b00);
      bus(1, 8'h00, 32'h0000_4073, 2'b00);
      bus(0, 8'h00, 0, 2'b00);
      chk(rd, 32'h0000_4003);
      bus(1, 8'h04, 32'hAA99_6655, 2'b00);
      bus(1, 8'h04, 32'h5566_99AA, 2'b00);
      bus(1, 8'h00, 32'h0000_4042, 2'b00);
      chk(32'({lower_alias_bank2, upper_alias_bank2}), 32'h0000_0002);
      $display("test gating done");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(32'({lower_alias_bank2, upper_alias_bank2}), 32'h0000_0002);
      aresetn <= 1'b1;
      bus(0, 8'h00, 0, 2'b00);
      chk(rd, 32'h0000_0042);
      por_resetn <= 1'b0;
      bus(0, 8'h00, 0, 2'b00);
      por_resetn <= 1'b1;
      bus(0, 8'h00, 0, 2'b00);
      chk(rd, 32'h0000_0000);
      bus(1, 8'h20, 32'h0000_0001, 2'b10);
      bus(0, 8'h20, 0, 2'b10);
      chk(rd, 32'h0000_0000);
      $display("test resets done");
      // every legal code once, then random legal codes, addresses, boundaries and ecc settings
      for (i = 0; i < 48; i = i + 1) begin
         op = (i < 8) ? i[3:0] : {1'b0, 3'($urandom)};
         a = $urandom & 32'h01FF_FFFF;
         b = ($urandom % 2) ? 24'h00_0000 : 24'($urandom & 32'h0007_FFFF);
         e = 2'($urandom);
         slow <= 1'($urandom);
         g = go(op, a, b, e);
         bus(1, 8'h08, a, 2'b00);
         bus(1, 8'h0C, 32'(b), 2'b00);
         bus(1, 8'h10, 32'(e), 2'b00);
         bus(1, 8'h00, 32'h0000_4000, 2'b00);
         n0 = ncmd;
         bus(1, 8'h00, 32'h0000_C000 | 32'(op), 2'b00);
         errx = !g && (op != 4'h0);
         rd = 32'h0000_8000;
         for (k = 0; rd[15] && k < 20; k = k + 1) bus(0, 8'h00, 0, 2'b00);
         if (rd[15]) begin
            err_count = err_count + 1;
            end_sim;
         end
         chk(32'(ncmd - n0), 32'(g));
         chk(32'(rd[13]), 32'(errx));
         if (g) chk(32'({flash_cmd_skip_ecc, flash_cmd_op}), 32'({op == 4'h1, op}));
         if (g) chk(flash_cmd_addr, a);
      end
      $display("test operations done");
      end_sim;
   end
endmodule
`default_nettype wire
